// ---- src/pb_reset.sv ----
// Pushbutton debounce and power-fail reset supervisor on an open-drain pin
`timescale 1ns/1ps
module pb_reset #(
  parameter longint unsigned RESET_CYC = pb_reset_pkg::RESET_ACTIVE_CYC,
  parameter longint unsigned DEBOUNCE_CYCLES = pb_reset_pkg::DEBOUNCE_CYC,
  parameter longint unsigned RECOVERY_CYCLES = pb_reset_pkg::RECOVERY_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic power_fail,
  input wire logic osc_disable_bit,
  input wire logic osc_running,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic reset_active
);
  import pb_reset_pkg::*;

  // Elaboration check on the delay counts; counters are CNT_W bits wide.
  // Our own release echoes low on the pin for three cycles, so a shorter
  // debounce would mistake that echo for a press.
  if (RESET_CYC < 64'h1 || DEBOUNCE_CYCLES < 64'h5 || RECOVERY_CYCLES < 64'h1 ||
      RESET_CYC > 64'h100000000 || DEBOUNCE_CYCLES > 64'h100000000 ||
      RECOVERY_CYCLES > 64'h100000000) begin : g_bad_counts
    $error("pb_reset: delay counts out of range");
  end

  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESET_CYC - 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYCLES - 1);

  // ==========================================================
  // Input synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] fail_sync_reg;
  logic [1:0] osc_sync_reg;
  logic [1:0] dis_sync_reg;

  // Two flops on every outside input except nrst and clk_en
  // Presets keep power fail asserted, so the pin stays low after nrst
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_reg <= 2'h3;
      fail_sync_reg <= 2'h3;
      osc_sync_reg <= 2'h0;
      dis_sync_reg <= 2'h0;
    end else if (clk_en) begin
      pin_sync_reg <= {pin_sync_reg[0], rst_pin_in};
      fail_sync_reg <= {fail_sync_reg[0], power_fail};
      osc_sync_reg <= {osc_sync_reg[0], osc_running};
      dis_sync_reg <= {dis_sync_reg[0], osc_disable_bit};
    end
  end

  logic pin_low;
  logic fail_s;
  logic osc_ok;
  logic osc_off;
  assign pin_low = !pin_sync_reg[1];
  assign fail_s = fail_sync_reg[1];
  assign osc_off = dis_sync_reg[1];
  assign osc_ok = osc_sync_reg[1] && !osc_off;

  // ==========================================================
  // Pushbutton debounce
  logic [CNT_W-1:0] deb_cnt_reg;
  logic button_req;
  sup_state_t state_reg;

  // Count while pin is low from outside; restart on any high sample
  // Own release echoes low for three cycles; the counter restarts after it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      deb_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!pin_low || state_reg != ST_RUN) begin
        deb_cnt_reg <= '0;
      end else if (deb_cnt_reg != DEB_LAST) begin
        deb_cnt_reg <= deb_cnt_reg + 1'b1;
      end
    end
  end

  // Request once stable low for the whole debounce interval
  assign button_req = pin_low && (deb_cnt_reg == DEB_LAST) && (state_reg == ST_RUN);

  // ==========================================================
  // Supervisor state machine
  logic [CNT_W-1:0] hold_cnt_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_HOLD_FAIL;
      hold_cnt_reg <= '0;
    end else if (clk_en) begin
      if (fail_s) begin
        state_reg <= ST_HOLD_FAIL;
        hold_cnt_reg <= '0;
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (button_req) begin
              state_reg <= ST_HOLD_BUTTON;
              hold_cnt_reg <= '0;
            end
          end
          ST_HOLD_FAIL: begin
            hold_cnt_reg <= '0;
            if (osc_off) begin
              state_reg <= ST_RUN;
            end else begin
              state_reg <= ST_HOLD_RECOVER;
            end
          end
          ST_HOLD_RECOVER: begin
            if (osc_off) begin
              state_reg <= ST_RUN;
            end else if (osc_ok) begin
              // Delay runs only while oscillator runs
              // Release once both the recovery and reset active times are met
              if (hold_cnt_reg >= REC_LAST && hold_cnt_reg >= RST_LAST) begin
                state_reg <= ST_RUN;
              end else begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
              end
            end
          end
          ST_HOLD_BUTTON: begin
            if (hold_cnt_reg == RST_LAST) begin
              state_reg <= ST_RUN;
            end else begin
              hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
          end
          default: begin
            state_reg <= ST_HOLD_FAIL;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Open-drain pin drive; output is always low, enable pulls it
  logic drive_reg;
  // Pull drops at once when the disable bit appears during recovery
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_reg <= 1'b1;
    end else if (clk_en) begin
      drive_reg <= fail_s || ((state_reg != ST_RUN) && !(state_reg == ST_HOLD_RECOVER
                   && osc_off)) || button_req;
    end
  end
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = drive_reg;
  // Status only; follows our own pull (drive_reg), not the pin level
  assign reset_active = drive_reg;

  // ==========================================================
  // Checks
  // Checks on state advance are gated by clk_en, since a low enable freezes all
  fail_pulls_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && fail_s |=> rst_pin_oe)
    else $error("power fail did not pull reset low");
  disable_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_HOLD_RECOVER && osc_off && !fail_s |=> state_reg == ST_RUN)
    else $error("oscillator disable did not skip recovery");
  recover_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_HOLD_RECOVER && !osc_ok && !osc_off && !fail_s
    |=> $stable(hold_cnt_reg) && state_reg == ST_HOLD_RECOVER)
    else $error("recovery delay advanced without oscillator");
  button_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_BUTTON |-> rst_pin_oe || $past(state_reg) != ST_HOLD_BUTTON)
    else $error("button hold released pin early");
  debounce_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_RUN && !button_req && !fail_s |=> state_reg == ST_RUN)
    else $error("reset entered without debounced request");
  pin_low_only_a: assert property (@(posedge core_clk) disable iff (!nrst)
    rst_pin_out == 1'b0)
    else $error("open-drain pin driven high");
  fail_state_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && fail_s |=> state_reg == ST_HOLD_FAIL)
    else $error("power fail not tracked");
  release_after_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_HOLD_BUTTON && hold_cnt_reg == RST_LAST && !fail_s
    |=> state_reg == ST_RUN)
    else $error("hold did not end at reset active time");
  skip_fail_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_HOLD_FAIL && osc_off && !fail_s |=> state_reg == ST_RUN)
    else $error("oscillator disable did not skip hold");
  recover_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && state_reg == ST_HOLD_RECOVER && osc_ok && !fail_s &&
    hold_cnt_reg >= REC_LAST && hold_cnt_reg >= RST_LAST |=> state_reg == ST_RUN)
    else $error("recovery hold did not end");
  button_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && button_req && !fail_s |=> state_reg == ST_HOLD_BUTTON && rst_pin_oe)
    else $error("debounced press did not pull reset low");
  freeze_state_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !clk_en |=> $stable(state_reg) && $stable(hold_cnt_reg) && $stable(drive_reg))
    else $error("state moved while clock enable low");

  // ==========================================================
  // Covers
  cov_fail_c: cover property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_RECOVER ##1 state_reg == ST_RUN);
  cov_button_c: cover property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_BUTTON ##1 state_reg == ST_RUN);
  cov_skip_c: cover property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_FAIL && osc_off ##1 state_reg == ST_RUN);
  cov_late_skip_c: cover property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_RECOVER && osc_off ##1 state_reg == ST_RUN);
  cov_freeze_c: cover property (@(posedge core_clk) disable iff (!nrst)
    state_reg == ST_HOLD_BUTTON && !clk_en);
endmodule

// ---- src/pb_reset_pkg.sv ----
// Constants for the pushbutton and power-fail reset supervisor
package pb_reset_pkg;
  // Core clock period in picoseconds (125 MHz)
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Reset active time and pushbutton debounce, in milliseconds
  localparam int unsigned RESET_ACTIVE_MS = 250;
  localparam int unsigned BUTTON_DEBOUNCE_MS = 250;
  // Power-up recovery delay, in milliseconds
  localparam int unsigned RECOVERY_MS = 250;
  // Cycle counts derived from the times (least times, rounded up)
  localparam int unsigned PS_PER_MS = 1000000000;
  localparam longint unsigned RESET_ACTIVE_CYC =
    (64'(RESET_ACTIVE_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned DEBOUNCE_CYC =
    (64'(BUTTON_DEBOUNCE_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned RECOVERY_CYC =
    (64'(RECOVERY_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Counter width for the long delays
  localparam int unsigned CNT_W = 32;
  // Supervisor states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD_FAIL,
    ST_HOLD_RECOVER,
    ST_HOLD_BUTTON
  } sup_state_t;
endpackage

// ---- verification/button_pin_model.sv ----
// Pushbutton and pull-up model on the shared reset line
`timescale 1ns/1ps
module button_pin_model (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic press,
  output logic rst_pin_in
);
  // Pull-up holds the line high unless device or button pulls low
  assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || press);
endmodule

// ---- verification/test_pb_reset.sv ----
// Self-checking bench for the reset supervisor
`timescale 1ns/1ps
module test_pb_reset;
  import pb_reset_pkg::*;
  localparam int RC = 8;
  localparam int DC = 10;
  localparam int VC = 12;
  typedef struct {logic val; int lo; int hi;} note_t;
  note_t notes[$];
  note_t cur;
  logic core_clk, nrst, clk_en, power_fail, osc_disable_bit, osc_running, press;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, reset_active, seen_level;
  int cyc = 0;
  int n_fail, n_compared;
  logic [31:0] lfsr;
  // ==========
  // Design and partner
  pb_reset #(.RESET_CYC(RC), .DEBOUNCE_CYCLES(DC), .RECOVERY_CYCLES(VC)) pb_reset_inst (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .power_fail(power_fail),
    .osc_disable_bit(osc_disable_bit), .osc_running(osc_running), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .reset_active(reset_active));
  button_pin_model button_pin_model_inst (.rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .press(press), .rst_pin_in(rst_pin_in));
  // ==========
  // Clock, cycle count and helpers
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic expect_edge(input logic v, input int lo, input int hi);
    notes.push_back('{v, cyc + lo, cyc + hi});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (notes.size() != 0 && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    if (notes.size() != 0) begin
      n_fail++;
      $display("unexpected pending_edges expected 0 seen %0d", notes.size());
    end
    idle(4);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Monitor: each output edge takes the oldest note
  always @(negedge core_clk) begin
    if (nrst && reset_active !== seen_level) begin
      n_compared++;
      if (notes.size() != 0) begin
        cur = notes.pop_front();
      end else begin
        cur = '{seen_level, -1, -1};
      end
      if (cur.val !== reset_active || cyc < cur.lo || cyc > cur.hi) begin
        n_fail++;
        $display("unexpected reset_active expected %b in %0d..%0d seen %b at %0d",
          cur.val, cur.lo, cur.hi, reset_active, cyc);
      end
      seen_level = reset_active;
    end
    if (nrst && rst_pin_oe === 1'b1 && rst_pin_out !== 1'b0) begin
      n_fail++;
      $display("unexpected rst_pin_out expected 0 seen %b", rst_pin_out);
    end
  end
  // Watchdog
  initial begin
    #(8 * 5000);
    n_fail++;
    complete_run();
  end
  // ==========
  // Main sequence
  initial begin
    nrst = 0; clk_en = 1; power_fail = 0; osc_disable_bit = 0; osc_running = 1;
    press = 0; n_fail = 0; n_compared = 0; seen_level = 1; lfsr = 32'hECFD;
    idle(10);
    nrst = 1;
    expect_edge(0, VC, VC + 9);
    drain();
    // Supply drop, recovery with a stalled oscillator
    power_fail = 1;
    expect_edge(1, 2, 5);
    idle(6);
    power_fail = 0;
    expect_edge(0, VC + 5, VC + 14);
    idle(6);
    osc_running = 0;
    idle(5);
    osc_running = 1;
    drain();
    // Oscillator disabled skips the recovery delay
    osc_disable_bit = 1;
    idle(3);
    power_fail = 1;
    expect_edge(1, 2, 5);
    idle(6);
    power_fail = 0;
    expect_edge(0, 1, 7);
    drain();
    osc_disable_bit = 0;
    // Disable set while the recovery delay is already running
    idle(3);
    power_fail = 1;
    expect_edge(1, 2, 5);
    idle(6);
    power_fail = 0;
    idle(6);
    osc_disable_bit = 1;
    expect_edge(0, 1, 6);
    drain();
    osc_disable_bit = 0;
    // Short glitches, then a held press
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      press = 1;
      idle(1 + int'(lfsr % (DC - 3)));
      press = 0;
      idle(4 + int'(lfsr[11:8]));
      press = 1;
      expect_edge(1, DC, DC + 5);
      expect_edge(0, DC + RC, DC + RC + 10);
      idle(DC + 6);
      press = 0;
      drain();
    end
    // Clock enable low freezes the button hold
    press = 1;
    expect_edge(1, DC, DC + 5);
    expect_edge(0, DC + RC + 6, DC + RC + 16);
    idle(DC + 6);
    press = 0;
    clk_en = 0;
    idle(6);
    clk_en = 1;
    drain();
    complete_run();
  end
endmodule
